// ===== logic/hbp_lane_swap.sv
`timescale 1ns/100ps
module hbp_lane_swap
  import hbp_pkg::*;
(
  input  wire logic        i_swap,
  input  wire logic [15:0] i_data,
  input  wire logic [1:0]  i_be,
  output logic      [15:0] o_data,
  output logic      [1:0]  o_be
);
  // ****************************************************
  // byte exchange between host order and little endian
  // ****************************************************
  wire logic [15:0] swapped_data;
  wire logic [1:0]  swapped_be;

  assign swapped_data = {i_data[HBP_LO_MSB:0], i_data[HBP_HI_MSB:HBP_HI_LSB]};
  assign swapped_be   = {i_be[0], i_be[1]};
  assign o_data       = i_swap ? swapped_data : i_data;
  assign o_be         = i_swap ? swapped_be : i_be;
endmodule

// ===== logic/hbp_muxed_host_bus_port.sv
`timescale 1ns/100ps
module hbp_muxed_host_bus_port
  import hbp_pkg::*;
#(
  parameter int DATA_W = HBP_DATA_W
)(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // configuration
  input  wire logic        i_cfg_direct_mapped,
  input  wire logic        i_cfg_bus16,
  input  wire logic        i_cfg_demux,
  input  wire logic        i_cfg_dual_phase,
  input  wire logic        i_cfg_ale_qualify,
  input  wire logic        i_cfg_rdwr_mode,
  input  wire logic        i_cfg_wait_ack_en,
  input  wire logic        i_cfg_pol_wait_ack,
  input  wire logic        i_cfg_pol_ale,
  input  wire logic        i_cfg_pol_cs,
  input  wire logic        i_cfg_pol_rd,
  input  wire logic        i_cfg_pol_wr,
  // host pins
  input  wire logic        i_cs,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic        i_addr_latch_low_strobe,
  input  wire logic        i_addr_latch_high_strobe,
  input  wire logic        i_endian,
  input  wire logic [1:0]  i_byte_lane_enables,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_ad,
  output logic      [15:0] o_ad,
  output logic             o_ad_lo_oe,
  output logic             o_ad_hi_oe,
  input  wire logic [7:0]  i_data_hi,
  output logic      [7:0]  o_data_hi,
  output logic             o_data_hi_oe,
  output logic             o_wait_ack,
  output logic             o_wait_ack_oe,
  // core side
  output logic      [15:0] o_core_addr,
  output logic      [15:0] o_core_wdata,
  output logic      [1:0]  o_core_be,
  output logic             o_core_wr,
  output logic             o_core_rd,
  input  wire logic [15:0] i_core_rdata,
  input  wire logic        i_core_busy
);
  if (DATA_W != HBP_DATA_W) begin : g_bad_width
    $error("only a 16-bit host data path is supported");
  end

  // ****************************************************
  // control line decode with per-line polarity, one polarity shared by both address strobes
  // ****************************************************
  wire logic cs_act;
  wire logic rd_pin_act;
  wire logic wr_pin_act;
  wire logic ale_lo_act;
  wire logic ale_hi_act;
  wire logic rd_act;
  wire logic wr_act;

  assign cs_act     = (i_cs == i_cfg_pol_cs);
  assign rd_pin_act = (i_rd == i_cfg_pol_rd);
  assign wr_pin_act = (i_wr == i_cfg_pol_wr);
  // in direction mode the read pin carries direction, the write pin enables
  assign rd_act = cs_act & (i_cfg_rdwr_mode ? (wr_pin_act & ~rd_pin_act)
                                            : rd_pin_act);
  assign wr_act = cs_act & (i_cfg_rdwr_mode ? (wr_pin_act & rd_pin_act)
                                            : wr_pin_act);
  assign ale_lo_act = (i_addr_latch_low_strobe == i_cfg_pol_ale) &
                      (cs_act | ~i_cfg_ale_qualify);
  assign ale_hi_act = (i_addr_latch_high_strobe == i_cfg_pol_ale) &
                      (cs_act | ~i_cfg_ale_qualify);

  // ****************************************************
  // address latches
  // ****************************************************
  // the latches follow the lines while the strobe is active, so the value
  // at the strobe's trailing edge is the one kept
  logic [7:0]  addr_lo_reg;
  logic [7:0]  addr_lo_next;
  logic [7:0]  addr_hi_reg;
  logic [7:0]  addr_hi_next;
  logic        endian_latch_reg;
  logic        endian_latch_next;
  wire logic   hi_from_ad;
  wire logic   any_ale;

  assign any_ale    = ale_lo_act | ale_hi_act;
  assign hi_from_ad = i_cfg_dual_phase ? ale_hi_act : ale_lo_act;
  // the low portion moves only on the low strobe, the high one on the high strobe (on the low strobe when not dual phase); otherwise kept
  assign addr_lo_next = (ale_lo_act & i_cfg_dual_phase) ? i_ad[HBP_LO_MSB:0] :
                        ale_lo_act ? i_ad[HBP_LO_MSB:0] :
                        addr_lo_reg;
  assign addr_hi_next = ~hi_from_ad ? addr_hi_reg :
                        i_cfg_dual_phase ? i_ad[HBP_LO_MSB:0] :
                        i_ad[HBP_HI_MSB:HBP_HI_LSB];
  assign endian_latch_next = any_ale ? i_endian : endian_latch_reg;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_lo_reg      <= HBP_BYTE_RST;
      addr_hi_reg      <= HBP_BYTE_RST;
      endian_latch_reg <= 1'b0;
    end else begin
      addr_lo_reg      <= addr_lo_next;
      addr_hi_reg      <= addr_hi_next;
      endian_latch_reg <= endian_latch_next;
    end
  end

  // ****************************************************
  // cycle sequencing
  // ****************************************************
  hbp_state_t  state_reg;
  hbp_state_t  state_next;
  logic        endian_cyc_reg;
  logic        endian_cyc_next;
  logic [15:0] wr_capture_reg;
  logic [15:0] wr_capture_next;
  logic [1:0]  be_capture_reg;
  logic [1:0]  be_capture_next;
  wire logic   cyc_start;
  wire logic   wr_end;

  assign cyc_start = (state_reg == HBP_IDLE) & (rd_act | wr_act);
  assign wr_end    = (state_reg == HBP_WRITE) & ~wr_act;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HBP_IDLE: begin
        if (rd_act) begin
          state_next = HBP_READ;
        end else if (wr_act) begin
          state_next = HBP_WRITE;
        end
      end
      HBP_READ: begin
        if (~rd_act) begin
          state_next = HBP_IDLE;
        end
      end
      HBP_WRITE: begin
        if (~wr_act) begin
          state_next = HBP_IDLE;
        end
      end
      default: begin
        state_next = HBP_IDLE;
      end
    endcase
  end

  // demultiplexed access takes endianness with the address at cycle start
  assign endian_cyc_next = ~cyc_start ? endian_cyc_reg :
                           i_cfg_demux ? i_endian :
                           endian_latch_reg;

  // ****************************************************
  // data lanes
  // ****************************************************
  wire logic        lane16;
  wire logic        single16;
  wire logic        use_d_hi;
  wire logic        do_swap;
  wire logic [15:0] host_wdata;
  wire logic [15:0] core_wdata_sw;
  wire logic [1:0]  core_be_sw;
  wire logic [15:0] host_rdata;
  wire logic [1:0]  legacy_be;
  wire logic [1:0]  be_in;
  wire logic        start_swap;
  wire logic [1:0]  be_start;

  assign lane16   = i_cfg_bus16;
  assign single16 = lane16 & ~i_cfg_demux & ~i_cfg_dual_phase;
  assign use_d_hi = lane16 & ~single16;
  // byte order only: the sequencing above never looks at endianness
  assign do_swap  = lane16 & (endian_cyc_reg == HBP_END_BIG);
  assign host_wdata = single16 ? i_ad :
                      use_d_hi ? {i_data_hi, i_ad[HBP_LO_MSB:0]} :
                      {HBP_BYTE_RST, i_ad[HBP_LO_MSB:0]};
  assign legacy_be = lane16 ? HBP_BE_BOTH : HBP_BE_LOW;
  assign be_in = ~i_cfg_direct_mapped ? legacy_be :
                 lane16 ? i_byte_lane_enables :
                 HBP_BE_LOW;

  // a read reports its enables at the start edge, before the cycle's
  // endianness and enables have reached their registers
  assign start_swap = lane16 & (endian_cyc_next == HBP_END_BIG);
  assign be_start   = start_swap ? {be_in[0], be_in[1]} : be_in;
  assign wr_capture_next = wr_act ? host_wdata : wr_capture_reg;
  assign be_capture_next = cyc_start ? be_in : be_capture_reg;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg      <= HBP_IDLE;
      endian_cyc_reg <= 1'b0;
      wr_capture_reg <= HBP_WORD_RST;
      be_capture_reg <= HBP_BE_NONE;
    end else begin
      state_reg      <= state_next;
      endian_cyc_reg <= endian_cyc_next;
      wr_capture_reg <= wr_capture_next;
      be_capture_reg <= be_capture_next;
    end
  end

  hbp_lane_swap u_wr_swap (
    .i_swap (do_swap),
    .i_data (wr_capture_reg),
    .i_be   (be_capture_reg),
    .o_data (core_wdata_sw),
    .o_be   (core_be_sw)
  );

  hbp_lane_swap u_rd_swap (
    .i_swap (do_swap),
    .i_data (i_core_rdata),
    .i_be   (HBP_BE_NONE),
    .o_data (host_rdata),
    .o_be   ()
  );

  // ****************************************************
  // core requests
  // ****************************************************
  wire logic [15:0] addr_now;
  wire logic [15:0] rdata_masked;

  assign addr_now = i_cfg_demux ? i_addr : {addr_hi_reg, addr_lo_reg};
  // 8-bit data leaves the upper byte of the core path at zero
  assign rdata_masked = lane16 ? host_rdata
                               : {HBP_BYTE_RST, i_core_rdata[HBP_LO_MSB:0]};

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_core_addr  <= HBP_WORD_RST;
      o_core_wdata <= HBP_WORD_RST;
      o_core_be    <= HBP_BE_NONE;
      o_core_wr    <= 1'b0;
      o_core_rd    <= 1'b0;
    end else begin
      o_core_rd <= cyc_start & rd_act;
      o_core_wr <= wr_end;
      if (cyc_start) begin
        o_core_addr <= addr_now;
      end
      if (cyc_start & rd_act) begin
        o_core_be <= i_cfg_direct_mapped ? be_start : be_in;
      end else if (wr_end) begin
        o_core_be <= i_cfg_direct_mapped ? core_be_sw : be_capture_reg;
      end
      if (wr_end) begin
        o_core_wdata <= lane16 ? core_wdata_sw
                               : {HBP_BYTE_RST, wr_capture_reg[HBP_LO_MSB:0]};
      end
    end
  end

  // ****************************************************
  // host read drive and wait/acknowledge
  // ****************************************************
  wire logic reading;
  wire logic wait_now;

  // the start edge counts too, so the lanes turn with the core read pulse
  assign reading  = (state_reg != HBP_WRITE) & rd_act;
  // legacy mode never stalls the host
  assign wait_now = i_cfg_direct_mapped & i_core_busy;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ad         <= HBP_WORD_RST;
      o_data_hi    <= HBP_BYTE_RST;
      o_ad_lo_oe   <= 1'b0;
      o_ad_hi_oe   <= 1'b0;
      o_data_hi_oe <= 1'b0;
    end else begin
      o_ad         <= rdata_masked;
      o_data_hi    <= rdata_masked[HBP_HI_MSB:HBP_HI_LSB];
      o_ad_lo_oe   <= reading;
      // the host may still hold upper address on these lines in 8-bit mode
      o_ad_hi_oe   <= reading & single16;
      o_data_hi_oe <= reading & use_d_hi;
    end
  end

  assign o_wait_ack    = wait_now ? i_cfg_pol_wait_ack
                                  : ~i_cfg_pol_wait_ack;
  assign o_wait_ack_oe = i_cfg_wait_ack_en & cs_act;
endmodule

// ===== logic/hbp_pkg.sv
package hbp_pkg;
  // ****************************************************
  // widths and lane positions
  // ****************************************************
  localparam int          HBP_DATA_W   = 16;
  localparam int          HBP_BYTE_W   = 8;
  localparam int          HBP_LO_MSB   = 7;
  localparam int          HBP_HI_LSB   = 8;
  localparam int          HBP_HI_MSB   = 15;
  // ****************************************************
  // reset values and fixed encodings
  // ****************************************************
  localparam logic [7:0]  HBP_BYTE_RST = 8'h00;
  localparam logic [15:0] HBP_WORD_RST = 16'h0000;
  localparam logic [1:0]  HBP_BE_NONE  = 2'h0;
  localparam logic [1:0]  HBP_BE_LOW   = 2'h1;
  localparam logic [1:0]  HBP_BE_BOTH  = 2'h3;
  localparam logic        HBP_END_BIG  = 1'b1;

  typedef enum logic [1:0] {
    HBP_IDLE,
    HBP_READ,
    HBP_WRITE
  } hbp_state_t;
endpackage

// ===== test/hbp_host_model.sv
`timescale 1ns/100ps
module hbp_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_act,
  input  wire logic        i_rw,
  input  wire logic        i_wide,
  input  wire logic [15:0] i_ad,
  input  wire logic        i_lo_oe,
  input  wire logic        i_hi_oe,
  input  wire logic [7:0]  i_dh,
  input  wire logic        i_dh_oe,
  output logic             o_cs,
  output logic             o_rd,
  output logic             o_wr,
  output logic             o_all,
  output logic             o_alh,
  output logic      [15:0] o_ad,
  output logic      [7:0]  o_dh
);
  logic [15:0] ad_r = 16'h0000;
  logic [7:0]  dh_r = 8'h00;
  logic        drv = 1'b0, cs_l = 1'b0, rd_l = 1'b0, wr_l = 1'b0;
  logic        dw = 1'b0, al_l = 1'b0, ah_l = 1'b0;
  // released lines invert, so a stale value can never pass for data
  assign o_ad[15:8] = i_hi_oe ? i_ad[15:8] : drv ? ad_r[15:8] : ~ad_r[15:8];
  assign o_ad[7:0]  = i_lo_oe ? i_ad[7:0] : drv ? ad_r[7:0] : ~ad_r[7:0];
  assign o_dh       = i_dh_oe ? i_dh : drv ? dh_r : ~dh_r;
  assign o_cs       = cs_l ~^ i_act;
  assign o_rd       = (i_rw ? dw : rd_l) ~^ i_act;
  assign o_wr       = (i_rw ? rd_l | wr_l : wr_l) ~^ i_act;
  assign o_all      = al_l ~^ i_act;
  assign o_alh      = ah_l ~^ i_act;
  task automatic latch(input logic hi, input logic c, input logic [15:0] a);
    @(posedge i_clk);
    #2;
    {cs_l, al_l, ah_l, drv} = {c, !hi, hi, 1'b1};
    ad_r = hi ? {a[7:0], a[15:8]} : a;
    @(posedge i_clk);
    #2;
    {cs_l, al_l, ah_l, drv} = 4'h0;
  endtask
  task automatic xfer(input logic w, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge i_clk);
    #2;
    {cs_l, dw, drv, rd_l, wr_l} = {1'b1, w, w, !w, w};
    ad_r = i_wide ? d : {~d[15:8], d[7:0]};
    dh_r = i_wide ? ~d[15:8] : d[15:8];
    repeat (4) @(posedge i_clk);
    q = {i_wide ? o_ad[15:8] : o_dh, o_ad[7:0]};
    #2;
    {drv, rd_l, wr_l} = 3'h0;
    @(posedge i_clk);
    #2;
    cs_l = 1'b0;
    repeat (2) @(posedge i_clk);
    #2;
  endtask
endmodule

// ===== test/hbp_muxed_host_bus_port_monitor.sv
`timescale 1ns/100ps
module hbp_muxed_host_bus_port_monitor (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic       i_cfg_direct_mapped,
  input wire logic       i_cfg_bus16,
  input wire logic       i_cfg_dual_phase,
  input wire logic       i_cfg_rdwr_mode,
  input wire logic       i_cfg_wait_ack_en,
  input wire logic       i_cfg_pol_wait_ack,
  input wire logic       i_cfg_pol_cs,
  input wire logic       i_cfg_pol_wr,
  input wire logic       i_cs,
  input wire logic       i_wr,
  input wire logic       i_endian,
  input wire logic [1:0] i_byte_lane_enables,
  input wire logic       o_ad_lo_oe,
  input wire logic       o_ad_hi_oe,
  input wire logic       o_data_hi_oe,
  input wire logic       o_wait_ack,
  input wire logic       o_wait_ack_oe,
  input wire logic [1:0] o_core_be,
  input wire logic       o_core_wr,
  input wire logic       o_core_rd
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_wt_leg;
    !i_cfg_direct_mapped |-> o_wait_ack != i_cfg_pol_wait_ack; endproperty
  a_wt_leg: assert property (p_wt_leg) else $error("wait shown");
  property p_wt_oe;
    o_wait_ack_oe == (i_cfg_wait_ack_en && i_cs == i_cfg_pol_cs); endproperty
  a_wt_oe: assert property (p_wt_oe) else $error("wait oe wrong");
  property p_no_hi;
    !i_cfg_bus16 |-> !o_data_hi_oe && !o_ad_hi_oe; endproperty
  a_no_hi: assert property (p_no_hi) else $error("upper lane driven");
  property p_be_leg; !i_cfg_direct_mapped && o_core_rd |->
    o_core_be == (i_cfg_bus16 ? 2'h3 : 2'h1); endproperty
  a_be_leg: assert property (p_be_leg) else $error("legacy be");
  property p_be_dir; i_cfg_direct_mapped && i_cfg_bus16 && o_core_rd |->
    o_core_be == (i_endian ? {i_byte_lane_enables[0],
    i_byte_lane_enables[1]} : i_byte_lane_enables); endproperty
  a_be_dir: assert property (p_be_dir) else $error("direct be");
  property p_rd;
    $rose(o_core_rd) |-> o_ad_lo_oe ##1 !o_core_rd; endproperty
  a_rd: assert property (p_rd) else $error("read pulse");
  property p_wr; !i_cfg_rdwr_mode && o_core_wr |->
    $past(i_wr) != i_cfg_pol_wr ##1 !o_core_wr; endproperty
  a_wr: assert property (p_wr) else $error("write pulse");
  property p_s16; !i_cfg_direct_mapped && !i_cfg_dual_phase && i_cfg_bus16
    && $rose(o_core_rd) |-> o_ad_hi_oe && !o_data_hi_oe; endproperty
  a_s16: assert property (p_s16) else $error("single lanes");
  property p_d16; !i_cfg_direct_mapped && i_cfg_dual_phase && i_cfg_bus16
    && $rose(o_core_rd) |-> o_data_hi_oe && !o_ad_hi_oe; endproperty
  a_d16: assert property (p_d16) else $error("dual lanes");
endmodule
bind hbp_muxed_host_bus_port hbp_muxed_host_bus_port_monitor i_mon (.*);

// ===== test/hbp_muxed_host_bus_port_tb_top.sv
`timescale 1ns/100ps
module hbp_muxed_host_bus_port_tb_top;
  import hbp_pkg::*;
  typedef struct packed {
    logic [4:0]  m; // direct, bus16, dual, big, high strobe first
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0]  b;
  } hbp_row_t;
  localparam hbp_row_t ROWS [7] = '{
    '{5'h18, 16'h0104, 16'h12AB, 16'h12AB, 2'h1},
    '{5'h1A, 16'h0106, 16'h12AB, 16'hAB12, 2'h2},
    '{5'h12, 16'h0108, 16'h00CD, 16'h00CD, 2'h1},
    '{5'h0C, 16'h0310, 16'h3456, 16'h3456, 2'h3},
    '{5'h0F, 16'h0512, 16'h3456, 16'h5634, 2'h3},
    '{5'h08, 16'h0714, 16'h789A, 16'h789A, 2'h3},
    '{5'h04, 16'h0916, 16'h00EF, 16'h00EF, 2'h1}};
  logic        i_sys_clk = 1'b0, i_reset = 1'b1, i_cfg_bus16 = 1'b0;
  logic        i_cfg_direct_mapped = 1'b0, i_cfg_dual_phase = 1'b0;
  logic        i_cfg_ale_qualify = 1'b0, i_cfg_rdwr_mode = 1'b0;
  logic        act = 1'b1, i_endian = 1'b0, i_core_busy = 1'b0;
  logic [15:0] i_addr = 16'h0000, i_core_rdata = 16'h0000, q, mk;
  logic [15:0] w_addr, w_wd, r_addr;
  logic [1:0]  i_byte_lane_enables = 2'h1, w_be;
  wire  [15:0] i_ad, o_ad, o_core_addr, o_core_wdata;
  wire  [7:0]  i_data_hi, o_data_hi;
  wire  [1:0]  o_core_be;
  wire         i_cs, i_rd, i_wr, i_addr_latch_low_strobe, o_ad_lo_oe;
  wire         i_addr_latch_high_strobe, o_ad_hi_oe, o_data_hi_oe;
  wire         o_wait_ack, o_wait_ack_oe, o_core_wr, o_core_rd;
  wire         ld = !i_cfg_direct_mapped && i_cfg_dual_phase;
  wire         wide = !i_cfg_direct_mapped && !i_cfg_dual_phase && i_cfg_bus16;
  int          n_errors = 0, cmp_count = 0;
  hbp_row_t    r;
  hbp_muxed_host_bus_port i_dut (
    .*,
    .i_cfg_demux        (i_cfg_direct_mapped),
    .i_cfg_wait_ack_en  (1'b1),
    .i_cfg_pol_wait_ack (act),
    .i_cfg_pol_ale      (act),
    .i_cfg_pol_cs       (act),
    .i_cfg_pol_rd       (act),
    .i_cfg_pol_wr       (act));
  hbp_host_model u_host (
    .i_clk(i_sys_clk), .i_act(act), .i_rw(i_cfg_rdwr_mode), .i_wide(wide),
    .i_ad(o_ad), .i_lo_oe(o_ad_lo_oe), .i_hi_oe(o_ad_hi_oe),
    .i_dh(o_data_hi), .i_dh_oe(o_data_hi_oe), .o_cs(i_cs), .o_rd(i_rd),
    .o_wr(i_wr), .o_all(i_addr_latch_low_strobe),
    .o_alh(i_addr_latch_high_strobe), .o_ad(i_ad), .o_dh(i_data_hi));
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_core_wr) {w_addr, w_wd, w_be} <= {o_core_addr, o_core_wdata, o_core_be};
    if (o_core_rd) r_addr <= o_core_addr;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    #2 i_reset = 1'b0;
    chk(o_core_addr, 16'h0000);
    chk({13'h0, o_ad_lo_oe, o_ad_hi_oe, o_data_hi_oe}, 16'h0000);
    chk({15'h0, o_wait_ack}, 16'h0000);
    // ****************************************************
    // table rows: write then read back one unit each
    // ****************************************************
    foreach (ROWS[k]) begin
      r = ROWS[k];
      {i_cfg_direct_mapped, i_cfg_bus16} = r.m[4:3];
      {i_cfg_dual_phase, i_endian} = r.m[2:1];
      {i_addr, i_core_rdata} = {r.a, r.e};
      mk = i_cfg_bus16 ? 16'hFFFF : 16'h00FF;
      if (ld && r.m[0]) u_host.latch(1'b1, 1'b1, r.a);
      if (!i_cfg_direct_mapped) u_host.latch(1'b0, 1'b1, r.a);
      if (ld && !r.m[0]) u_host.latch(1'b1, 1'b1, r.a);
      u_host.xfer(1'b1, r.d, q);
      chk(w_addr, r.a);
      chk(w_wd & mk, r.e & mk);
      chk({14'h0, w_be}, {14'h0, r.b});
      u_host.xfer(1'b0, 16'h0000, q);
      chk(q & mk, r.d & mk);
      chk(r_addr, r.a);
    end
    // ****************************************************
    // skipped strobes, qualification, inverted controls
    // ****************************************************
    u_host.latch(1'b0, 1'b1, 16'h0017);
    u_host.xfer(1'b0, 16'h0000, q);
    chk(r_addr, 16'h0917);
    {i_cfg_bus16, i_cfg_dual_phase} = 2'b10;
    u_host.latch(1'b0, 1'b1, 16'h0A20);
    repeat (2) begin
      u_host.xfer(1'b0, 16'h0000, q);
      chk(r_addr, 16'h0A20);
    end
    for (int k = 0; k < 2; k++) begin
      i_cfg_ale_qualify = (k == 0);
      u_host.latch(1'b0, 1'b0, 16'h0B30);
      u_host.xfer(1'b0, 16'h0000, q);
      chk(r_addr, k ? 16'h0B30 : 16'h0A20);
    end
    {act, i_cfg_rdwr_mode, i_cfg_dual_phase} = 3'b011;
    u_host.latch(1'b0, 1'b1, 16'h0C40);
    u_host.latch(1'b1, 1'b1, 16'h0C40);
    u_host.xfer(1'b1, 16'h5A3C, q);
    chk(w_wd, 16'h5A3C);
    i_core_rdata = 16'h1234;
    u_host.xfer(1'b0, 16'h0000, q);
    chk(q, 16'h1234);
    chk(r_addr, 16'h0C40);
    {i_cfg_direct_mapped, i_core_busy} = 2'b11;
    #1;
    chk({15'h0, o_wait_ack}, {15'h0, act});
    close_out;
  end
endmodule
